// File: uart_glb_pkg.sv
// Purpose: Shared constants for the quad UART global configuration and interrupt block.
// Assumes: An 8-bit host bus with a 256-byte map and four channel blocks of 16 bytes.
// Notes:   Every offset, field position, reset value and source code is named once here.
package uart_glb_pkg;

  // ----------------------------------------------------------------
  // Bus and map geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 8;
  localparam int          CODE_W      = 3;
  localparam logic [7:0]  CHAN_TOP    = 8'h3F;
  localparam logic [3:0]  CFG_PAGE    = 4'h8;
  localparam logic [7:0]  REG_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Global configuration register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  SVC_FLAGS_ADDR   = 8'h80;
  localparam logic [7:0]  SRC_LOW_ADDR     = 8'h81;
  localparam logic [7:0]  SRC_HIGH_ADDR    = 8'h82;
  localparam logic [7:0]  SRC_UNUSED_ADDR  = 8'h83;
  localparam logic [7:0]  TMR_CTRL_ADDR    = 8'h84;
  localparam logic [7:0]  TMR_PLACE_ADDR   = 8'h85;
  localparam logic [7:0]  TMR_LOW_ADDR     = 8'h86;
  localparam logic [7:0]  TMR_HIGH_ADDR    = 8'h87;
  localparam logic [7:0]  RATE_SEL_ADDR    = 8'h88;
  localparam logic [7:0]  SPARE_A_ADDR     = 8'h89;
  localparam logic [7:0]  SOFT_RST_ADDR    = 8'h8A;
  localparam logic [7:0]  SLEEP_EN_ADDR    = 8'h8B;
  localparam logic [7:0]  REVISION_ADDR    = 8'h8C;
  localparam logic [7:0]  IDENT_ADDR       = 8'h8D;
  localparam logic [7:0]  BCAST_ADDR       = 8'h8E;

  // ----------------------------------------------------------------
  // Channel register offsets whose reads clear latched sources
  // ----------------------------------------------------------------
  localparam logic [3:0]  CH_STATUS_OFF = 4'h2;
  localparam logic [3:0]  CH_LINE_OFF   = 4'h5;
  localparam logic [3:0]  CH_MODEM_OFF  = 4'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENA_RX_BIT      = 0;
  localparam int ENA_TX_BIT      = 1;
  localparam int ENA_LINE_BIT    = 2;
  localparam int ENA_MODEM_BIT   = 3;
  localparam int ENA_FLOW_BIT    = 5;
  localparam int TMR_INT_EN_BIT  = 0;
  localparam int TMR_RUN_BIT     = 1;
  localparam int TMR_ONESHOT_BIT = 2;
  localparam int TMR_EXTCLK_BIT  = 3;
  localparam int BCAST_BIT       = 0;
  localparam logic [3:0] ALL_ASLEEP = 4'hF;

  // ----------------------------------------------------------------
  // Source codes, lowest nonzero value is the highest priority
  // ----------------------------------------------------------------
  localparam logic [2:0]  CODE_NONE  = 3'h0;
  localparam logic [2:0]  CODE_RX    = 3'h1;
  localparam logic [2:0]  CODE_TOUT  = 3'h2;
  localparam logic [2:0]  CODE_TX    = 3'h3;
  localparam logic [2:0]  CODE_MODEM = 3'h4;
  localparam logic [2:0]  CODE_TIMER = 3'h7;

endpackage : uart_glb_pkg

// File: chan_src_if.sv
// Purpose: Carries one channel's masked interrupt sources and its encoded source code.
// Assumes: Sources are already gated by the relevant enable bits.
// Notes:   The collector drives sources, the encoder returns the code.
interface chan_src_if;
  logic       rx_data;
  logic       rx_err;
  logic       rx_tout;
  logic       tx_rdy;
  logic       modem;
  logic       timer;
  logic [2:0] code;

  modport encoder (input rx_data, rx_err, rx_tout, tx_rdy, modem, timer, output code);
  modport collector (output rx_data, rx_err, rx_tout, tx_rdy, modem, timer, input code);
endinterface : chan_src_if

// File: source_encoder.sv
// Purpose: Priority encoder turning one channel's pending sources into a 3-bit code.
// Assumes: Inputs are masked levels; the code is combinational.
// Notes:   Only the channel built with TIMER_ALLOWED set can ever report the timer code.
module source_encoder #(
  parameter bit TIMER_ALLOWED = 1'b0
) (
  // Source bundle
  chan_src_if.encoder src
);

  // ----------------------------------------------------------------
  // Priority selection
  // ----------------------------------------------------------------
  // Receive wins over time-out, then transmit, modem and timer last.
  wire   rx_any    = src.rx_data | src.rx_err;
  wire   timer_any = TIMER_ALLOWED & src.timer;
  assign src.code  = rx_any      ? uart_glb_pkg::CODE_RX    :
                     src.rx_tout ? uart_glb_pkg::CODE_TOUT  :
                     src.tx_rdy  ? uart_glb_pkg::CODE_TX    :
                     src.modem   ? uart_glb_pkg::CODE_MODEM :
                     timer_any   ? uart_glb_pkg::CODE_TIMER :
                                   uart_glb_pkg::CODE_NONE;

endmodule : source_encoder

// File: event_latch.sv
// Purpose: A row of sticky flags set by event pulses and cleared by read strobes.
// Assumes: Set and clear are synchronous single-cycle strobes.
// Notes:   A set in the same cycle as a clear keeps the flag, so no event is lost.
module event_latch #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  // Strobes
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clr_i,
  // Flags
  output logic      [WIDTH-1:0] flag_o
);

  logic [WIDTH-1:0] flag;
  wire  [WIDTH-1:0] next_flag = set_i | (flag & ~clr_i);

  // Flags hold until cleared.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) flag <= '0;
    else           flag <= next_flag;
  end

  assign flag_o = flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_set_beats_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    set_i[0] |=> flag_o[0])
    else $error("Flag lost an event that arrived during its clear.");

endmodule : event_latch

// File: quad_uart_global_int_config.sv
// Purpose: Global configuration registers and interrupt aggregation for a four-channel UART.
// Assumes: Host strobes rd_i and wr_i are one-cycle pulses synchronous to core_clk_i;
//          channel read data is valid combinationally during chan_rd_o.
// Notes:   Read data appears in rdata_o one cycle after rd_i and holds until the next read.
//
// What this block does
// - Channel blocks of 16 bytes each: channel 0 lowest, then 1, 2, 3.
// - Global registers live in a 16-byte region at 0x80, always reachable.
// - Service flags hold one bit per channel; upper four bits read zero.
// - Service bit is one while requesting, cleared after the clearing status read.
// - Two locator registers pack four 3-bit codes; channel 3 sits in bits 3..1.
// - Each code reports highest pending source; 5 and 6 never produced.
// - Code 1 is receive data at trigger or a line error, each with own clear.
// - Code 2 is receive time-out, cleared only when the receive FIFO empties.
// - Code 3 is transmit ready, holding or shift empty; cleared by status read.
// - Code 4 is modem or flow change, or special character, each with own clear.
// - Code 7 is timer time-out, channel 0 only, cleared by reading timer control.
// - All four interrupt registers reset to zero.
// - The fourth interrupt register always reads zero.
// - Channel sources masked by channel enables; timer and wake by own registers.
// - Wake-up with all channels asleep raises an interrupt cleared by reading flags.
// - Timer control: interrupt enable, run, one-shot select, clock select.
// - Soft-reset bits reset their channel and clear themselves.
// - Sampling bit per channel: zero for 16x, one for 8x.
// - Broadcast bit makes channel writes reach all four channels.
module quad_uart_global_int_config #(
  parameter int         NUM_CHAN   = 4,
  parameter logic [7:0] REVISION   = 8'h01,  // Arbitrary neutral value.
  parameter logic [7:0] IDENT_CODE = 8'h5A   // Arbitrary neutral value.
) (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  // Host bus
  input  wire logic [7:0]            addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [7:0]            rdata_o,
  // Channel register access
  output logic      [NUM_CHAN-1:0]   chan_wr_o,
  output logic      [NUM_CHAN-1:0]   chan_rd_o,
  output logic      [3:0]            chan_addr_o,
  output logic      [7:0]            chan_wdata_o,
  input  wire logic [NUM_CHAN-1:0][7:0] chan_rdata_i,
  // Channel controls
  output logic      [NUM_CHAN-1:0]   chan_soft_reset_o,
  output logic      [NUM_CHAN-1:0]   eight_x_o,
  output logic      [NUM_CHAN-1:0]   sleep_enable_o,
  // Channel interrupt sources
  input  wire logic [NUM_CHAN-1:0][7:0] int_enable_i,
  input  wire logic [NUM_CHAN-1:0]   rx_trigger_i,
  input  wire logic [NUM_CHAN-1:0][3:0] line_err_i,
  input  wire logic [NUM_CHAN-1:0]   rx_timeout_i,
  input  wire logic [NUM_CHAN-1:0]   holding_empty_i,
  input  wire logic [NUM_CHAN-1:0]   shift_empty_i,
  input  wire logic [NUM_CHAN-1:0]   half_duplex_i,
  input  wire logic [NUM_CHAN-1:0]   modem_change_i,
  input  wire logic [NUM_CHAN-1:0]   flow_char_i,
  // Timer and sleep
  input  wire logic                  timer_timeout_i,
  input  wire logic                  wake_i,
  output logic                       timer_run_o,
  output logic                       timer_one_shot_o,
  output logic                       timer_ext_clk_o,
  output logic      [15:0]           timer_reload_o,
  // Interrupt
  output logic                       int_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The locator packing is fixed for exactly four channels.
  if (NUM_CHAN != 4) begin : g_bad_chan
    $error("NUM_CHAN must be 4 for this register layout.");
  end

  // Matches a read or write to one register of one channel block.
  function automatic logic chan_hit(input logic [7:0] addr, input int ch, input logic [3:0] off);
    chan_hit = (addr <= uart_glb_pkg::CHAN_TOP) && (addr[5:4] == ch[1:0]) && (addr[3:0] == off);
  endfunction : chan_hit

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire                chan_space = (addr_i <= uart_glb_pkg::CHAN_TOP);
  wire                cfg_space  = (addr_i[7:4] == uart_glb_pkg::CFG_PAGE);
  wire [3:0]          chan_onehot = 4'h1 << addr_i[5:4];
  wire                host_rd    = rd_i;
  wire                host_wr    = wr_i;
  wire                cfg_wr     = host_wr & cfg_space;
  wire                rd_flags   = host_rd & (addr_i == uart_glb_pkg::SVC_FLAGS_ADDR);
  wire                rd_tmr     = host_rd & (addr_i == uart_glb_pkg::TMR_CTRL_ADDR);

  // ----------------------------------------------------------------
  // Global configuration registers
  // ----------------------------------------------------------------
  logic [3:0]  timer_ctrl;
  logic [15:0] timer_count;
  logic [3:0]  rate_sel;
  logic [3:0]  sleep_en;
  logic [3:0]  soft_rst;
  logic        bcast;

  // Writes to the reserved range match no register and so have no effect.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      timer_ctrl  <= uart_glb_pkg::REG_RESET[3:0];
      timer_count <= {uart_glb_pkg::REG_RESET, uart_glb_pkg::REG_RESET};
      rate_sel    <= uart_glb_pkg::REG_RESET[3:0];
      sleep_en    <= uart_glb_pkg::REG_RESET[3:0];
      bcast       <= 1'b0;
    end else if (cfg_wr) begin
      case (addr_i)
        uart_glb_pkg::TMR_CTRL_ADDR: timer_ctrl        <= wdata_i[3:0];
        uart_glb_pkg::TMR_LOW_ADDR:  timer_count[7:0]  <= wdata_i;
        uart_glb_pkg::TMR_HIGH_ADDR: timer_count[15:8] <= wdata_i;
        uart_glb_pkg::RATE_SEL_ADDR: rate_sel          <= wdata_i[3:0];
        uart_glb_pkg::SLEEP_EN_ADDR: sleep_en          <= wdata_i[3:0];
        uart_glb_pkg::BCAST_ADDR:    bcast             <= wdata_i[uart_glb_pkg::BCAST_BIT];
        default: ;
      endcase
    end
  end

  // Soft reset is a one-cycle pulse, so software never has to clear it.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) soft_rst <= 4'h0;
    else           soft_rst <= (cfg_wr && addr_i == uart_glb_pkg::SOFT_RST_ADDR) ?
                               wdata_i[3:0] : 4'h0;
  end

  // Control outputs straight from their registers.
  assign timer_run_o       = timer_ctrl[uart_glb_pkg::TMR_RUN_BIT];
  assign timer_one_shot_o  = timer_ctrl[uart_glb_pkg::TMR_ONESHOT_BIT];
  assign timer_ext_clk_o   = timer_ctrl[uart_glb_pkg::TMR_EXTCLK_BIT];
  assign timer_reload_o    = timer_count;
  assign eight_x_o         = rate_sel;
  assign sleep_enable_o    = sleep_en;
  assign chan_soft_reset_o = soft_rst;

  // ----------------------------------------------------------------
  // Channel access
  // ----------------------------------------------------------------
  // Strobes are combinational so the channel sees address and data in the same cycle.
  assign chan_addr_o  = addr_i[3:0];
  assign chan_wdata_o = wdata_i;
  assign chan_rd_o    = (host_rd && chan_space) ? chan_onehot : 4'h0;
  assign chan_wr_o    = (host_wr && chan_space) ? (bcast ? 4'hF : chan_onehot) : 4'h0;

  // ----------------------------------------------------------------
  // Per-channel sources and codes
  // ----------------------------------------------------------------
  chan_src_if src [NUM_CHAN] ();
  logic [NUM_CHAN-1:0][2:0] code;
  logic [NUM_CHAN-1:0]      svc;
  logic                     timer_flag;
  logic                     wake_flag;

  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    wire       rd_status = host_rd & chan_hit(addr_i, g, uart_glb_pkg::CH_STATUS_OFF);
    wire       rd_line   = host_rd & chan_hit(addr_i, g, uart_glb_pkg::CH_LINE_OFF);
    wire       rd_modem  = host_rd & chan_hit(addr_i, g, uart_glb_pkg::CH_MODEM_OFF);
    wire       tx_event  = half_duplex_i[g] ? shift_empty_i[g] : holding_empty_i[g];
    wire [3:0] set_vec   = {flow_char_i[g], modem_change_i[g], tx_event, |line_err_i[g]};
    wire [3:0] clr_vec   = {rd_status | soft_rst[g], rd_modem | soft_rst[g],
                            rd_status | soft_rst[g], rd_line | soft_rst[g]};
    wire [7:0] int_en    = int_enable_i[g];
    logic [3:0] held;

    // Held flags: line error, transmit ready, modem change, special character.
    event_latch #(.WIDTH(4)) u_held (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .set_i      (set_vec),
      .clr_i      (clr_vec),
      .flag_o     (held)
    );

    // Enables gate sources so a masked source never shows in any view.
    assign src[g].rx_data = rx_trigger_i[g] & int_en[uart_glb_pkg::ENA_RX_BIT];
    assign src[g].rx_err  = held[0] & int_en[uart_glb_pkg::ENA_LINE_BIT];
    assign src[g].rx_tout = rx_timeout_i[g] & int_en[uart_glb_pkg::ENA_RX_BIT];
    assign src[g].tx_rdy  = held[1] & int_en[uart_glb_pkg::ENA_TX_BIT];
    assign src[g].modem   = (held[2] & int_en[uart_glb_pkg::ENA_MODEM_BIT]) |
                            (held[3] & int_en[uart_glb_pkg::ENA_FLOW_BIT]);
    assign src[g].timer   = (g == 0) && timer_flag &&
                            timer_ctrl[uart_glb_pkg::TMR_INT_EN_BIT];

    source_encoder #(.TIMER_ALLOWED(g == 0)) u_enc (
      .src (src[g])
    );

    assign code[g] = src[g].code;
    assign svc[g]  = (src[g].code != uart_glb_pkg::CODE_NONE);
  end

  // ----------------------------------------------------------------
  // Timer and wake-up flags
  // ----------------------------------------------------------------
  // Timer only latches while enabled; wake only latches when every channel sleeps.
  wire timer_set = timer_timeout_i & timer_ctrl[uart_glb_pkg::TMR_INT_EN_BIT];
  wire wake_set  = wake_i & (sleep_en == uart_glb_pkg::ALL_ASLEEP);

  event_latch #(.WIDTH(2)) u_glb_flags (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .set_i      ({wake_set, timer_set}),
    .clr_i      ({rd_flags, rd_tmr}),
    .flag_o     ({wake_flag, timer_flag})
  );

  // The wake-up interrupt carries no code; it only asserts the shared line.
  assign int_o = (|svc) | wake_flag;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] src_low  = {code[2][1:0], code[1], code[0]};
  wire [7:0] src_high = {4'h0, code[3], code[2][2]};
  wire [7:0] cfg_rdata =
    (addr_i == uart_glb_pkg::SVC_FLAGS_ADDR) ? {4'h0, svc}         :
    (addr_i == uart_glb_pkg::SRC_LOW_ADDR)   ? src_low             :
    (addr_i == uart_glb_pkg::SRC_HIGH_ADDR)  ? src_high            :
    (addr_i == uart_glb_pkg::TMR_CTRL_ADDR)  ? {4'h0, timer_ctrl}  :
    (addr_i == uart_glb_pkg::TMR_LOW_ADDR)   ? timer_count[7:0]    :
    (addr_i == uart_glb_pkg::TMR_HIGH_ADDR)  ? timer_count[15:8]   :
    (addr_i == uart_glb_pkg::RATE_SEL_ADDR)  ? {4'h0, rate_sel}    :
    (addr_i == uart_glb_pkg::SLEEP_EN_ADDR)  ? {4'h0, sleep_en}    :
    (addr_i == uart_glb_pkg::REVISION_ADDR)  ? REVISION            :
    (addr_i == uart_glb_pkg::IDENT_ADDR)     ? IDENT_CODE          :
    (addr_i == uart_glb_pkg::BCAST_ADDR)     ? {7'h00, bcast}      :
                                               8'h00;
  wire [7:0] read_value = chan_space ? chan_rdata_i[addr_i[5:4]] :
                          cfg_space  ? cfg_rdata : 8'h00;

  // Read data holds between reads so a slow host can sample it late.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i)    rdata_o <= uart_glb_pkg::REG_RESET;
    else if (host_rd) rdata_o <= read_value;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_chan_read_decode: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (rd_i && addr_i <= 8'h3F) |-> (chan_rd_o == (4'h1 << addr_i[5:4])))
    else $error("Channel read strobe decoded to the wrong block.");

  a_sleep_write_back: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == 8'h8B) |=> (sleep_enable_o == $past(wdata_i[3:0])))
    else $error("Global register write did not take effect.");

  a_flags_upper_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (rd_i && addr_i == 8'h80) |=> (rdata_o[7:4] == 4'h0 && rdata_o[3:0] == $past(svc)))
    else $error("Service flag read returned wrong bits.");

  a_no_reserved_code: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (code[0] != 3'h5) && (code[0] != 3'h6) && (code[1] < 3'h5) && (code[2] < 3'h5) &&
    (code[3] < 3'h5))
    else $error("A reserved source code was produced.");

  a_rx_top_priority: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (rx_trigger_i[1] && int_enable_i[1][0]) |-> (code[1] == 3'h1))
    else $error("Receive source did not take top priority.");

  a_timer_clear_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (rd_i && addr_i == 8'h84 && !timer_timeout_i) |=> (code[0] != 3'h7))
    else $error("Timer code survived a timer control read.");

  a_unused_reads_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (rd_i && (addr_i == 8'h83 || addr_i == 8'h89)) |=> (rdata_o == 8'h00))
    else $error("Unused register read was not zero.");

  a_wake_clear_read: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wake_flag && rd_i && addr_i == 8'h80 && !wake_i) |=> !wake_flag)
    else $error("Wake-up interrupt survived a flag read.");

  a_soft_reset_pulse: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i == 8'h8A && wdata_i[0]) ##1 !(wr_i && addr_i == 8'h8A)
      |-> chan_soft_reset_o[0] ##1 !chan_soft_reset_o[0])
    else $error("Soft reset bit did not clear itself.");

  a_bcast_all_chans: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_i && addr_i <= 8'h3F && bcast) |-> (chan_wr_o == 4'hF))
    else $error("Broadcast write missed a channel.");

  a_reserved_reads: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (rd_i && addr_i[7:6] == 2'b01) |=> (rdata_o == 8'h00))
    else $error("Reserved range read was not zero.");

  c_bcast_write: cover property (@(posedge core_clk_i) wr_i && bcast && addr_i <= 8'h3F);
  c_timer_code:  cover property (@(posedge core_clk_i) code[0] == 3'h7);
  c_wake_int:    cover property (@(posedge core_clk_i) wake_flag && !(|svc));
  c_all_pending: cover property (@(posedge core_clk_i) svc == 4'hF);

endmodule : quad_uart_global_int_config

// File: host_model.sv
// Purpose: Host processor model for the 8-bit register bus.
// Assumes: Strobes change only at the falling edge of the clock.
// Notes:   Read and write are never raised together; one idle cycle follows each access.
module host_model (
  // Clock
  input  wire logic       core_clk_i,
  // Bus
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // One access: a strobe of one cycle, released before the next request.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    {addr_o, wdata_o, wr_o, rd_o} = {a, d, w, !w};
    @(negedge core_clk_i);
    {wr_o, rd_o} = 2'b00;
  endtask : xfer
  initial {addr_o, wdata_o, wr_o, rd_o} = '0;
endmodule : host_model

// File: testbench.sv
// Purpose: Self-checking bench for the global configuration and interrupt block.
// Assumes: The host model drives the bus; channel-side inputs come from here.
// Notes:   Reads queue their expected data; a monitor compares it a cycle later.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic            core_clk_i = 1'b0, sys_rst_i = 1'b1, timer_timeout_i = 1'b0, wake_i = 1'b0;
  logic            wr_i, rd_i;
  logic      [7:0] addr_i, wdata_i, rdata_o, r, exp_q[$];
  logic [3:0][7:0] chan_rdata_i, int_enable_i;
  logic [3:0][3:0] line_err_i = '0;
  logic      [3:0] rx_trigger_i = '0, rx_timeout_i = '0, holding_empty_i = '0, shift_empty_i = '0;
  logic      [3:0] half_duplex_i = '0, modem_change_i = '0, flow_char_i = '0;
  logic      [3:0] chan_soft_reset_o, eight_x_o, chan_wr_o, chan_rd_o, chan_addr_o, sleep_enable_o;
  logic      [7:0] chan_wdata_o;
  logic     [15:0] timer_reload_o;
  logic            int_o, timer_run_o, timer_one_shot_o, timer_ext_clk_o;
  int              seed = 51359, bad_count = 0, total_checks = 0;
  host_model host (.core_clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
  quad_uart_global_int_config dut (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask : rd
  // A channel write notes the strobe pattern that the channels should see.
  task automatic wr_ch(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b1, a, d);
  endtask : wr_ch
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  // Clock and a watchdog sized well beyond the short sequence below.
  initial forever #5 core_clk_i = ~core_clk_i;
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
  // Read data is registered, so it is compared at the falling edge after the strobe.
  // Channel strobes are combinational, so they are compared at their own strobe edge.
  always @(posedge core_clk_i) begin
    if (wr_i === 1'b1) begin
      chk({4'h0, chan_wr_o}, (addr_i < 8'h40) ? exp_q.pop_front() : 8'h00);
      chk(chan_wdata_o, wdata_i);
    end
    if (rd_i === 1'b1) begin
      if (addr_i < 8'h40) chk({chan_rd_o, chan_addr_o}, {4'h1 << addr_i[5:4], addr_i[3:0]});
      @(negedge core_clk_i);
      chk(rdata_o, exp_q.pop_front());
    end
  end
  // Main sequence; source pulses last one cycle, as the channels give them.
  initial begin
    chan_rdata_i = {$random(seed), $random(seed)};
    int_enable_i = {4{8'hFF}};
    r = 8'($random(seed));
    repeat (2) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    for (int i = 0; i < 4; i++) rd(8'(8'h80 + i), 8'h00);
    host.xfer(1'b1, 8'h88, {4'h0, r[3:0]});
    rd(8'h88, {4'h0, r[3:0]});
    chk({4'h0, eight_x_o}, {4'h0, r[3:0]});
    host.xfer(1'b1, 8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    @(negedge core_clk_i) holding_empty_i[0] = 1'b1;
    @(negedge core_clk_i) holding_empty_i[0] = 1'b0;
    rd(8'h80, 8'h01);
    rd(8'h81, 8'h03);
    rd(8'h02, chan_rdata_i[0]);
    rd(8'h80, 8'h00);
    @(negedge core_clk_i) {line_err_i[3], modem_change_i[2]} = 5'h05;
    @(negedge core_clk_i) {line_err_i[3], modem_change_i[2]} = 5'h00;
    rd(8'h80, 8'h0C);
    rd(8'h81, 8'h00);
    rd(8'h82, 8'h03);
    rd(8'h35, chan_rdata_i[3]);
    rd(8'h26, chan_rdata_i[2]);
    rd(8'h82, 8'h00);
    // Receive data outranks a pending time-out; a cleared enable hides the time-out.
    @(negedge core_clk_i) {rx_trigger_i[1], rx_timeout_i[1]} = 2'b11;
    rd(8'h81, 8'h08);
    @(negedge core_clk_i) rx_trigger_i[1] = 1'b0;
    rd(8'h81, 8'h10);
    @(negedge core_clk_i) int_enable_i[1] = 8'h00;
    rd(8'h80, 8'h00);
    @(negedge core_clk_i) {rx_timeout_i[1], int_enable_i[1]} = {1'b0, 8'hFF};
    // In half-duplex mode only the shift register empty event counts.
    @(negedge core_clk_i) {half_duplex_i[2], holding_empty_i[2]} = 2'b11;
    @(negedge core_clk_i) holding_empty_i[2] = 1'b0;
    rd(8'h80, 8'h00);
    @(negedge core_clk_i) shift_empty_i[2] = 1'b1;
    @(negedge core_clk_i) shift_empty_i[2] = 1'b0;
    rd(8'h80, 8'h04);
    rd(8'h22, chan_rdata_i[2]);
    rd(8'h80, 8'h00);
    host.xfer(1'b1, 8'h84, 8'h0F);
    chk({5'h00, timer_ext_clk_o, timer_one_shot_o, timer_run_o}, 8'h07);
    @(negedge core_clk_i) timer_timeout_i = 1'b1;
    @(negedge core_clk_i) timer_timeout_i = 1'b0;
    rd(8'h81, 8'h07);
    rd(8'h84, 8'h0F);
    rd(8'h81, 8'h00);
    host.xfer(1'b1, 8'h86, r);
    host.xfer(1'b1, 8'h87, ~r);
    chk(timer_reload_o[7:0], r);
    chk(timer_reload_o[15:8], ~r);
    wr_ch(8'h12, r, 8'h02);
    host.xfer(1'b1, 8'h8E, 8'h01);
    wr_ch(8'h31, r, 8'h0F);
    rd(8'h8E, 8'h01);
    // Wake-up with every channel asleep raises the line but no service bit.
    host.xfer(1'b1, 8'h8B, 8'h0F);
    chk({4'h0, sleep_enable_o}, 8'h0F);
    @(negedge core_clk_i) wake_i = 1'b1;
    @(negedge core_clk_i) wake_i = 1'b0;
    chk({7'h00, int_o}, 8'h01);
    rd(8'h80, 8'h00);
    chk({7'h00, int_o}, 8'h00);
    host.xfer(1'b1, 8'h8A, 8'h05);
    chk({4'h0, chan_soft_reset_o}, 8'h05);
    repeat (2) @(negedge core_clk_i);
    complete_run();
  end
endmodule : testbench
